//--- core/iplr_top.sv
// priority level register bank for registers three (tail) to six with request forwarding
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module iplr_top (
  input  wire logic                            clk_sys_i,
  input  wire logic                            reset_i,
  input  wire iplr_pkg::iplr_bus_req_t         bus_req_i,
  output logic      [iplr_pkg::DATA_W-1:0]     rdata_o,
  input  wire logic [iplr_pkg::NUM_SRC-1:0]    src_req_i,
  output iplr_pkg::iplr_fwd_t [iplr_pkg::NUM_SRC-1:0] fwd_o,
  output logic                                 any_fwd_o,
  output logic      [1:0]                      max_level_o
);
  import iplr_pkg::*;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // field code to forwarding tag; 00 never forwards, others map
  // one below the code so the range stops at level 2
  function automatic iplr_fwd_t decode_code(input logic [1:0] code);
    iplr_fwd_t res;
    res.active = (code != CODE_MASKED);
    res.level  = (code == CODE_MASKED) ? 2'h0 : code - 2'h1;
    return res;
  endfunction : decode_code

  // pick one 2-bit field out of a register word
  function automatic logic [1:0] pick_field(
    input logic [DATA_W-1:0] word,
    input logic [3:0]        lsb
  );
    logic [DATA_W-1:0] shifted;
    shifted = word >> lsb;
    return shifted[1:0];
  endfunction : pick_field

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [NUM_REGS-1:0] hit_reg;
  logic                hit_pend_low;
  logic                hit_pend_high;
  logic                hit_any;
  logic [NUM_REGS-1:0] wr_reg;

  // word offsets: slot 0..3 stand at offsets three to six
  assign hit_reg[0]    = (bus_req_i.addr == OFS_LEVEL_THREE);
  assign hit_reg[1]    = (bus_req_i.addr == OFS_LEVEL_FOUR);
  assign hit_reg[2]    = (bus_req_i.addr == OFS_LEVEL_FIVE);
  assign hit_reg[3]    = (bus_req_i.addr == OFS_LEVEL_SIX);
  assign hit_pend_low  = (bus_req_i.addr == OFS_PEND_LOW);
  assign hit_pend_high = (bus_req_i.addr == OFS_PEND_HIGH);
  assign hit_any       = (|hit_reg) | hit_pend_low | hit_pend_high;

  // writes to status or unmapped offsets are dropped silently
  assign wr_reg = hit_reg & {NUM_REGS{bus_req_i.wr}};

  // ---------------------------------------------------------------
  // register words
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] reg_word [NUM_REGS];

  // register three: only bits 5-2 belong to this bank
  iplr_level_word #(
    .WMASK (MASK_THREE)
  ) u_word_three (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .wr_en_i   (wr_reg[0]),
    .wdata_i   (bus_req_i.wdata),
    .word_o    (reg_word[0])
  );

  // register four: reserved bits 9-6
  iplr_level_word #(
    .WMASK (MASK_FOUR)
  ) u_word_four (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .wr_en_i   (wr_reg[1]),
    .wdata_i   (bus_req_i.wdata),
    .word_o    (reg_word[1])
  );

  // register five: reserved bits 7-6
  iplr_level_word #(
    .WMASK (MASK_FIVE)
  ) u_word_five (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .wr_en_i   (wr_reg[2]),
    .wdata_i   (bus_req_i.wdata),
    .word_o    (reg_word[2])
  );

  // register six: reserved bits 5-4
  iplr_level_word #(
    .WMASK (MASK_SIX)
  ) u_word_six (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .wr_en_i   (wr_reg[3]),
    .wdata_i   (bus_req_i.wdata),
    .word_o    (reg_word[3])
  );

  // ---------------------------------------------------------------
  // named level fields, as the core side sees them
  // ---------------------------------------------------------------
  logic [1:0] can_error_level;
  logic [1:0] can_bus_off_level;
  logic [1:0] serial_periph0_rx_full_level;
  logic [1:0] serial_periph1_tx_empty_level;
  logic [1:0] serial_periph1_rx_full_level;
  logic [1:0] port_a_pin_level;
  logic [1:0] port_b_pin_level;
  logic [1:0] port_c_pin_level;
  logic [1:0] decoder1_index_level;
  logic [1:0] decoder1_home_watchdog_level;
  logic [1:0] async_serial1_rx_full_level;
  logic [1:0] async_serial1_rx_error_level;
  logic [1:0] async_serial1_tx_idle_level;
  logic [1:0] async_serial1_tx_empty_level;
  logic [1:0] serial_periph0_tx_empty_level;
  logic [1:0] timer_grp_c_ch0_level;
  logic [1:0] timer_grp_d_ch3_level;
  logic [1:0] timer_grp_d_ch2_level;
  logic [1:0] timer_grp_d_ch1_level;
  logic [1:0] timer_grp_d_ch0_level;
  logic [1:0] decoder0_index_level;
  logic [1:0] decoder0_home_watchdog_level;
  logic [1:0] field_code [NUM_SRC];

  // each source field is pulled by its slot and lsb from the map
  generate
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_field
      assign field_code[s] = pick_field(reg_word[SRC_SLOT[s]], SRC_LSB[s]);
    end
  endgenerate

  // register three tail
  assign can_error_level               = field_code[0];
  assign can_bus_off_level             = field_code[1];
  // register four
  assign serial_periph0_rx_full_level  = field_code[2];
  assign serial_periph1_tx_empty_level = field_code[3];
  assign serial_periph1_rx_full_level  = field_code[4];
  assign port_a_pin_level              = field_code[5];
  assign port_b_pin_level              = field_code[6];
  assign port_c_pin_level              = field_code[7];
  // register five
  assign decoder1_index_level          = field_code[8];
  assign decoder1_home_watchdog_level  = field_code[9];
  assign async_serial1_rx_full_level   = field_code[10];
  assign async_serial1_rx_error_level  = field_code[11];
  assign async_serial1_tx_idle_level   = field_code[12];
  assign async_serial1_tx_empty_level  = field_code[13];
  assign serial_periph0_tx_empty_level = field_code[14];
  // register six
  assign timer_grp_c_ch0_level         = field_code[15];
  assign timer_grp_d_ch3_level         = field_code[16];
  assign timer_grp_d_ch2_level         = field_code[17];
  assign timer_grp_d_ch1_level         = field_code[18];
  assign timer_grp_d_ch0_level         = field_code[19];
  assign decoder0_index_level          = field_code[20];
  assign decoder0_home_watchdog_level  = field_code[21];

  // forwarding decodes the named fields, so each source name is the one
  // place where its request meets its register bits
  logic [1:0] named_code [NUM_SRC];

  assign named_code[0]  = can_error_level;
  assign named_code[1]  = can_bus_off_level;
  assign named_code[2]  = serial_periph0_rx_full_level;
  assign named_code[3]  = serial_periph1_tx_empty_level;
  assign named_code[4]  = serial_periph1_rx_full_level;
  assign named_code[5]  = port_a_pin_level;
  assign named_code[6]  = port_b_pin_level;
  assign named_code[7]  = port_c_pin_level;
  assign named_code[8]  = decoder1_index_level;
  assign named_code[9]  = decoder1_home_watchdog_level;
  assign named_code[10] = async_serial1_rx_full_level;
  assign named_code[11] = async_serial1_rx_error_level;
  assign named_code[12] = async_serial1_tx_idle_level;
  assign named_code[13] = async_serial1_tx_empty_level;
  assign named_code[14] = serial_periph0_tx_empty_level;
  assign named_code[15] = timer_grp_c_ch0_level;
  assign named_code[16] = timer_grp_d_ch3_level;
  assign named_code[17] = timer_grp_d_ch2_level;
  assign named_code[18] = timer_grp_d_ch1_level;
  assign named_code[19] = timer_grp_d_ch0_level;
  assign named_code[20] = decoder0_index_level;
  assign named_code[21] = decoder0_home_watchdog_level;

  // ---------------------------------------------------------------
  // request forwarding
  // ---------------------------------------------------------------
  iplr_fwd_t [NUM_SRC-1:0] fwd_r;
  iplr_fwd_t [NUM_SRC-1:0] fwd_nxt;

  // a request passes only when its field is not masked; a masked
  // source keeps a zero tag so the core never sees stale levels
  generate
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_fwd
      iplr_fwd_t dec;
      assign dec = decode_code(named_code[s]);
      assign fwd_nxt[s].active = src_req_i[s] & dec.active;
      assign fwd_nxt[s].level  = fwd_nxt[s].active ? dec.level : 2'h0;
    end
  endgenerate

  // one register stage keeps the tags glitch free toward the core
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fwd_r <= '0;
    end else begin
      fwd_r <= fwd_nxt;
    end
  end

  assign fwd_o = fwd_r;

  // ---------------------------------------------------------------
  // summary of forwarded requests
  // ---------------------------------------------------------------
  logic       any_nxt;
  logic [1:0] max_nxt;
  logic       any_r;
  logic [1:0] max_r;

  // highest level among the forwarded set; no vectoring here
  always_comb begin
    any_nxt = 1'b0;
    max_nxt = 2'h0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (fwd_nxt[s].active) begin
        any_nxt = 1'b1;
        if (fwd_nxt[s].level > max_nxt) begin
          max_nxt = fwd_nxt[s].level;
        end
      end
    end
  end

  // registered alongside the tags so both change on the same edge
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      any_r <= 1'b0;
      max_r <= 2'h0;
    end else begin
      any_r <= any_nxt;
      max_r <= (max_nxt > LEVEL_MAX) ? LEVEL_MAX : max_nxt;
    end
  end

  assign any_fwd_o   = any_r;
  assign max_level_o = max_r;

  // ---------------------------------------------------------------
  // pending status words
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0]     pend_vec;
  logic [DATA_W-1:0]      pend_low_word;
  logic [DATA_W-1:0]      pend_high_word;

  // live forwarded set, as of the last clock edge
  generate
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_pend
      assign pend_vec[s] = fwd_r[s].active;
    end
  endgenerate

  assign pend_low_word  = pend_vec[DATA_W-1:0];
  assign pend_high_word = {{(DATA_W-PEND_HIGH_W){1'b0}}, pend_vec[NUM_SRC-1:DATA_W]};

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // unmapped offsets answer zero; reserved bits are already zero
  // in the stored words, so no extra masking is needed here
  assign rd_mux = hit_reg[0]    ? reg_word[0] :
                  hit_reg[1]    ? reg_word[1] :
                  hit_reg[2]    ? reg_word[2] :
                  hit_reg[3]    ? reg_word[3] :
                  hit_pend_low  ? pend_low_word :
                  hit_pend_high ? pend_high_word :
                  16'h0000;

  // data stand only in the cycle after the read strobe
  assign rdata_nxt = (bus_req_i.rd & hit_any) ? rd_mux : 16'h0000;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

endmodule : iplr_top
`default_nettype wire

//--- shared/iplr_pkg.sv
// constants, field layout and carrier types for the interrupt priority level register bank
//
// Summary of operation
// - code 00 masks, 01..11 give levels 0..2
// - every field resets to the masked code
// - selectable levels are exactly 0, 1, 2
// - reserved bits read zero, ignore writes
// - register three bits 5-4: CAN error level
// - register three bits 3-2: CAN bus-off level
// - register four holds three serial-peripheral levels
// - register four bits 5-0: port A, B, C
// - register five 15-12: decoder 1 index, home/watchdog
// - register five holds four async serial 1 levels
// - register five bits 1-0: serial-peripheral 0 tx empty
// - register six 15-8: timer C0, D3, D2, D1
// - registers four to six are 16 bits at offsets 4..6
// - register six 7-0: timer D0, reserved, decoder 0
package iplr_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------
  // register offsets (word offsets from the controller base)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_LEVEL_THREE = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_FOUR  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_FIVE  = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_SIX   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_PEND_LOW    = 4'he;
  localparam logic [ADDR_W-1:0] OFS_PEND_HIGH   = 4'hf;

  // ---------------------------------------------------------------
  // writable-bit masks, one per level register, and one reset value shared by all four
  // ---------------------------------------------------------------
  localparam int NUM_REGS = 4;
  localparam logic [DATA_W-1:0] MASK_THREE = 16'h003c;
  localparam logic [DATA_W-1:0] MASK_FOUR  = 16'hfc3f;
  localparam logic [DATA_W-1:0] MASK_FIVE  = 16'hff3f;
  localparam logic [DATA_W-1:0] MASK_SIX   = 16'hffcf;
  localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;

  // ---------------------------------------------------------------
  // field codes and levels
  // ---------------------------------------------------------------
  localparam logic [1:0] CODE_MASKED = 2'h0;
  localparam logic [1:0] LEVEL_MAX   = 2'h2;

  // ---------------------------------------------------------------
  // source map: register slot (0 = three .. 3 = six) and field lsb
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 22;
  localparam int PEND_HIGH_W = NUM_SRC - DATA_W;
  localparam logic [1:0] SRC_SLOT [NUM_SRC] = '{
    2'h0, 2'h0,                          // can error, can bus-off
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,  // serial periph, ports a..c
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3
  };
  localparam logic [3:0] SRC_LSB [NUM_SRC] = '{
    4'h4, 4'h2,
    4'he, 4'hc, 4'ha, 4'h4, 4'h2, 4'h0,
    4'he, 4'hc, 4'ha, 4'h8, 4'h4, 4'h2, 4'h0,
    4'he, 4'hc, 4'ha, 4'h8, 4'h6, 4'h2, 4'h0
  };

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } iplr_bus_req_t;

  typedef struct packed {
    logic       active;
    logic [1:0] level;
  } iplr_fwd_t;

endpackage : iplr_pkg

//--- core/iplr_level_word.sv
// one priority level register word with a fixed writable-bit mask
`timescale 1ns/10ps
`default_nettype none
module iplr_level_word
  import iplr_pkg::*;
#(
  parameter logic [iplr_pkg::DATA_W-1:0] WMASK = 16'h0000
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       reset_i,
  input  wire logic                       wr_en_i,
  input  wire logic [iplr_pkg::DATA_W-1:0] wdata_i,
  output logic      [iplr_pkg::DATA_W-1:0] word_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] word_r;
  logic [DATA_W-1:0] word_nxt;

  // reserved positions never store, so they always read zero
  assign word_nxt = wr_en_i ? (wdata_i & WMASK) : word_r;

  // only a write or reset moves the word
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      word_r <= RESET_WORD;
    end else begin
      word_r <= word_nxt;
    end
  end

  assign word_o = word_r;

endmodule : iplr_level_word
`default_nettype wire

//--- testbench/iplr_checker.sv
// port assertions for the priority level register bank
`timescale 1ns/10ps
`default_nettype none
module iplr_checker
  import iplr_pkg::*;
(
  input  wire logic                                   clk_sys_i,
  input  wire logic                                   reset_i,
  input  wire iplr_pkg::iplr_bus_req_t                bus_req_i,
  input  wire logic [iplr_pkg::DATA_W-1:0]            rdata_o,
  input  wire logic [iplr_pkg::NUM_SRC-1:0]           src_req_i,
  input  wire iplr_pkg::iplr_fwd_t [iplr_pkg::NUM_SRC-1:0] fwd_o,
  input  wire logic                                   any_fwd_o,
  input  wire logic [1:0]                             max_level_o
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] act_w;
  logic [1:0]         top_w;
  logic [DATA_W-1:0]  rmask_r;
  // readable mask per address; pending words are status, unmapped reads all zero
  wire logic [DATA_W-1:0] amask_w = (bus_req_i.addr == OFS_LEVEL_THREE) ? MASK_THREE :
                                    (bus_req_i.addr == OFS_LEVEL_FOUR)  ? MASK_FOUR  :
                                    (bus_req_i.addr == OFS_LEVEL_FIVE)  ? MASK_FIVE  :
                                    (bus_req_i.addr == OFS_LEVEL_SIX)   ? MASK_SIX   :
                                    (bus_req_i.addr == OFS_PEND_LOW)    ? 16'hffff   :
                                    (bus_req_i.addr == OFS_PEND_HIGH)   ? 16'h003f   : 16'h0000;
  // highest forwarded level, recomputed from the outputs themselves
  always_comb begin
    top_w = 2'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      act_w[i] = fwd_o[i].active;
      if (fwd_o[i].active && fwd_o[i].level > top_w) top_w = fwd_o[i].level;
    end
  end
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) rmask_r <= 16'h0000;
    else rmask_r <= amask_w;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_rdata_idle: assert property (!$past(bus_req_i.rd) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside read slot");
  a_rsvd_zero: assert property ($past(bus_req_i.rd) |-> (rdata_o & ~rmask_r) == 16'h0000)
    else $error("reserved or unmapped bits read nonzero");
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    a_level_range: assert property (fwd_o[g].level <= LEVEL_MAX && (fwd_o[g].active || fwd_o[g].level == 2'h0))
      else $error("forwarded level out of range");
    a_fwd_cause: assert property (fwd_o[g].active |-> $past(src_req_i[g]))
      else $error("forward without source request");
  end
  a_any_or: assert property (any_fwd_o == |act_w)
    else $error("any flag disagrees with forwards");
  a_max_level: assert property (max_level_o == top_w)
    else $error("max level disagrees with forwards");
  a_post_reset: assert property ($past(reset_i) |-> !any_fwd_o && max_level_o == 2'h0 && rdata_o == 16'h0000)
    else $error("outputs not clear after reset");
  a_fwd_stable: assert property (!$past(bus_req_i.wr, 2) && $past(src_req_i) == $past(src_req_i, 2) |-> $stable(fwd_o))
    else $error("forward changed without write or request change");
  c_read: cover property (bus_req_i.rd ##1 rdata_o != 16'h0000);
  c_write: cover property (bus_req_i.wr && bus_req_i.addr == OFS_LEVEL_SIX);
  c_top: cover property (any_fwd_o && max_level_o == LEVEL_MAX);
endmodule : iplr_checker
`default_nettype wire

//--- testbench/iplr_core_model.sv
// behavioural model of the peripheral request lines and the core's level intake
`timescale 1ns/10ps
`default_nettype none
module iplr_core_model
  import iplr_pkg::*;
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_i,
  input  wire logic [iplr_pkg::NUM_SRC-1:0] pattern_i,
  input  wire logic                         any_fwd_i,
  input  wire logic [1:0]                   max_level_i,
  output logic      [iplr_pkg::NUM_SRC-1:0] src_req_o,
  output logic      [1:0]                   taken_level_o
);
  // request lines move just after an edge, as peripheral flags do
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      src_req_o     <= '0;
      taken_level_o <= 2'h0;
    end else begin
      src_req_o     <= pattern_i;
      taken_level_o <= any_fwd_i ? max_level_i : 2'h0;
    end
  end
endmodule : iplr_core_model
`default_nettype wire

//--- testbench/iplr_top_bench.sv
// self-checking bench for the priority level register bank
`timescale 1ns/10ps
`default_nettype none
module iplr_top_bench;
  import iplr_pkg::*;
  // ---------------------------------------------------------------
  // signals and models
  // ---------------------------------------------------------------
  localparam int             EXP_W = 3 * NUM_SRC + 21;
  logic                      clk_sys_i;
  logic                      reset_i;
  iplr_bus_req_t             bus_req_i;
  logic [DATA_W-1:0]         rdata_o;
  wire logic [NUM_SRC-1:0]   src_req_i;
  logic [NUM_SRC-1:0]        pat_r;
  iplr_fwd_t [NUM_SRC-1:0]   fwd_o;
  logic                      any_fwd_o;
  logic [1:0]                max_level_o;
  wire logic [1:0]           core_lvl;
  int                        err_total = 0;
  int                        n_tests = 0;
  logic [31:0]               rng = 32'h815f;
  logic [DATA_W-1:0]         mdl [4];
  logic [EXP_W-1:0]          exp_q [$];
  logic                      rd_pend = 1'b0;

  iplr_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_req_i(bus_req_i), .rdata_o(rdata_o),
    .src_req_i(src_req_i), .fwd_o(fwd_o), .any_fwd_o(any_fwd_o), .max_level_o(max_level_o));
  iplr_core_model core (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pattern_i(pat_r), .any_fwd_i(any_fwd_o),
    .max_level_i(max_level_o), .src_req_o(src_req_i), .taken_level_o(core_lvl));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  // expected {forwards, core intake, any, max level, read data} from the model and request pattern
  function automatic logic [EXP_W-1:0] expect_rd(input logic [ADDR_W-1:0] a);
    logic [NUM_SRC-1:0]   pend;
    logic [3*NUM_SRC-1:0] fv;
    logic [1:0]         top;
    logic [1:0]         code;
    logic [DATA_W-1:0]  d;
    top = 2'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      code = mdl[SRC_SLOT[i]][SRC_LSB[i] +: 2];
      pend[i] = pat_r[i] && code != CODE_MASKED;
      fv[3*i +: 3] = {pend[i], pend[i] ? code - 2'h1 : 2'h0};
      if (pend[i] && code - 2'h1 > top) top = code - 2'h1;
    end
    if (a >= OFS_LEVEL_THREE && a <= OFS_LEVEL_SIX) d = mdl[a - OFS_LEVEL_THREE];
    else if (a == OFS_PEND_LOW) d = pend[15:0];
    else if (a == OFS_PEND_HIGH) d = {10'h000, pend[21:16]};
    else d = 16'h0000;
    return {fv, top, |pend, top, d};
  endfunction : expect_rd
  // ---------------------------------------------------------------
  // bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] m;
    m = (a == OFS_LEVEL_THREE) ? MASK_THREE : (a == OFS_LEVEL_FOUR) ? MASK_FOUR :
        (a == OFS_LEVEL_FIVE) ? MASK_FIVE : MASK_SIX;
    @(posedge clk_sys_i);
    bus_req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    if (a >= OFS_LEVEL_THREE && a <= OFS_LEVEL_SIX) mdl[a - OFS_LEVEL_THREE] = d & m;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys_i);
    bus_req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    exp_q.push_back(expect_rd(a));
  endtask : rd
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      bus_req_i <= '0;
    end
  endtask : idle
  task automatic check(input logic [EXP_W-1:0] got, input logic [EXP_W-1:0] want);
    n_tests++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------
  // clock, watchdog, monitor
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // run needs well under 1000 cycles; the margin covers a stalled sequence
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
  always @(posedge clk_sys_i) rd_pend <= bus_req_i.rd;
  // read data stands only in the cycle after the strobe, so look mid-cycle
  always @(negedge clk_sys_i) begin
    if (rd_pend && !reset_i) begin : chk
      logic [EXP_W-1:0] e;
      e = exp_q.pop_front();
      check({fwd_o, core_lvl, any_fwd_o, max_level_o, rdata_o}, e);
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    bus_req_i = '0;
    pat_r = '0;
    for (int i = 0; i < 4; i++) mdl[i] = RESET_WORD;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 16; a++) rd(a[3:0]);
    idle(2);
    $display("test reset values done");
    // all ones everywhere, pending and unmapped words included, back to back
    for (int a = 0; a < 16; a++) wr(a[3:0], 16'hffff);
    for (int a = 0; a < 16; a++) rd(a[3:0]);
    idle(2);
    $display("test reserved bits done");
    pat_r <= '1;
    for (int c = 0; c < 4; c++) begin
      for (int a = 3; a < 7; a++) wr(a[3:0], {8{c[1:0]}});
      idle(3);
      rd(OFS_PEND_LOW);
      rd(OFS_PEND_HIGH);
      rd(OFS_LEVEL_SIX);
    end
    idle(2);
    $display("test field codes done");
    for (int n = 0; n < 30; n++) begin
      rng = xs(rng);
      wr(OFS_LEVEL_THREE + rng[1:0], rng[31:16]);
      rng = xs(rng);
      pat_r <= rng[NUM_SRC-1:0];
      idle(3);
      rd(OFS_PEND_LOW);
      rd(OFS_PEND_HIGH);
      rd(OFS_LEVEL_THREE + rng[25:24]);
    end
    idle(2);
    $display("test random levels done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 4; i++) mdl[i] = RESET_WORD;
    for (int a = 3; a < 7; a++) rd(a[3:0]);
    idle(3);
    rd(OFS_PEND_LOW);
    idle(2);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : iplr_top_bench

bind iplr_top iplr_checker u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_req_i(bus_req_i),
  .rdata_o(rdata_o), .src_req_i(src_req_i), .fwd_o(fwd_o), .any_fwd_o(any_fwd_o), .max_level_o(max_level_o));
`default_nettype wire
